// File: rsrx_pkg.sv
// rsrx_pkg: lane codes, column patterns, counts and state types for the
// receive-side lane decoder and link fault monitor.
// assumes an eight-lane, 64-bit receive column with one control bit per lane.
package rsrx_pkg;

  localparam int LANES = 8;
  localparam int LANE_W = 8;
  localparam int COL_W = LANES * LANE_W;

  // control character codes when a lane's control bit is high
  localparam logic [7:0] CODE_IDLE = 8'h07;
  localparam logic [7:0] CODE_SEQ = 8'h9c;
  localparam logic [7:0] CODE_START = 8'hfb;
  localparam logic [7:0] CODE_TERM = 8'hfd;
  localparam logic [7:0] CODE_ERR = 8'hfe;

  // sequence ordered set contents
  localparam logic [7:0] SEQ_PAD = 8'h00;
  localparam logic [7:0] SEQ_LOCAL = 8'h01;
  localparam logic [7:0] SEQ_REMOTE = 8'h02;
  localparam int SEQ_TYPE_LANE = 3;
  localparam int SFD_LANE = 7;

  // transmit columns forced while a fault is held
  localparam logic [63:0] RF_TXD = 64'h0000_0000_0200_009c;
  localparam logic [7:0] RF_TXC = 8'h01;
  localparam logic [63:0] IDLE_TXD = 64'h0707_0707_0707_0707;
  localparam logic [7:0] IDLE_TXC = 8'hff;

  // fault monitor counts
  localparam int COL_LIMIT = 128;
  localparam int SEQ_SET = 4;
  localparam int CNT_W = 8;
  localparam int SEQ_W = 3;

  typedef enum logic [1:0] {
    RSRX_LF_OK = 2'b00,
    RSRX_LF_LOCAL = 2'b01,
    RSRX_LF_REMOTE = 2'b10
  } rsrx_fault_t;

  typedef enum logic {
    RSRX_FR_IDLE = 1'b0,
    RSRX_FR_DATA = 1'b1
  } rsrx_frame_t;

endpackage : rsrx_pkg

// File: rsrx_top.sv
// rsrx_top: receive lane decoder and link fault monitor of the reconciliation
// layer, with the fault-driven steering of what the transmit path sends.
// assumes rx_clk, rxc and rxd come from the phy domain; mac_tx_active is on mclk.
// Behaviour
// R1: phy holds a lane's control bit low for data, high for control.
// R2: phy changes control and data only with the receive clock rising edge.
// R3: lane n of the data bus is bits 8n+7 down to 8n.
// R4: control 07 idle, fd terminate, fe error; data any value; others reserved.
// R5: sequence and start codes are valid only on lane 0.
// R6: phy sends preamble as data after a lane-0 start character.
// R7: every data lane is passed to the mac as eight data bits.
// R8: phy flags detected errors with the error control character.
// R9: non-terminate control inside a frame forces a frame check error.
// R10: each error character yields eight bits; other ending control adds eight.
// R11: transmit may carry an error character to corrupt a frame deliberately.
// R12: a start not on lane 0 never raises data valid.
// R13: frames whose delimiter is not in lane 7 are dropped.
// R14: fault sets span a whole lane-0 aligned column with lanes 4-7 zero.
// R15: the eight lanes of one clock are handled as one column.
// R16: local fault received: stop mac data, send remote fault sets.
// R17: remote fault received: stop mac data, send idle only.
// R18: without fault sets, normal transmission resumes.
// R19: local fault is sequence, 01 on lane 3, zero elsewhere.
// R20: remote fault is sequence, 02 on lane 3, zero elsewhere.
// R21: other sequence sets are reserved and never count as faults.
// R22: only this layer sends remote fault; the phy sends local fault.
// R23: fault set after four same-type sets under 128 columns apart.
// R24: fault returns to ok after 128 columns with no fault set.
// R25: data valid ends on terminate or any other ending control.
// R26: reset clears counters and sets fault status to ok.
`timescale 1ns/1ps

module rsrx_top #(
  parameter logic [7:0] SFD_OCTET = 8'hd5,
  parameter logic [7:0] PRE_OCTET = 8'h55,
  parameter logic [7:0] ERR_OCTET = 8'h00
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rx_clk,
  input wire logic [7:0] rxc,
  input wire logic [63:0] rxd,
  input wire logic mac_tx_active,
  output logic [63:0] mac_rxd,
  output logic [7:0] mac_lane_vld,
  output logic mac_col_stb,
  output logic mac_dvalid,
  output logic mac_rx_err,
  output logic mac_frame_end,
  output logic [1:0] link_fault,
  output logic tx_ovr_en,
  output logic [63:0] tx_ovr_txd,
  output logic [7:0] tx_ovr_txc,
  output logic tx_force_err
);

  // lane n byte of a column
  function automatic logic [7:0] lane_byte(input logic [63:0] d, input int n);
    lane_byte = d[n*rsrx_pkg::LANE_W +: rsrx_pkg::LANE_W]; // R3
  endfunction : lane_byte

  // fault type carried by a column, ok when it is no fault set
  function automatic rsrx_pkg::rsrx_fault_t col_fault(input logic [7:0] c, input logic [63:0] d);
    logic pad_ok;
    pad_ok = 1'b1;
    col_fault = rsrx_pkg::RSRX_LF_OK;
    for (int n = 1; n < rsrx_pkg::LANES; n++) begin
      if (n != rsrx_pkg::SEQ_TYPE_LANE && lane_byte(d, n) != rsrx_pkg::SEQ_PAD) begin
        pad_ok = 1'b0; // R14
      end
    end
    if (c == 8'h01 && lane_byte(d, 0) == rsrx_pkg::CODE_SEQ && pad_ok) begin // R5 R15
      if (lane_byte(d, rsrx_pkg::SEQ_TYPE_LANE) == rsrx_pkg::SEQ_LOCAL) begin
        col_fault = rsrx_pkg::RSRX_LF_LOCAL; // R19
      end else if (lane_byte(d, rsrx_pkg::SEQ_TYPE_LANE) == rsrx_pkg::SEQ_REMOTE) begin
        col_fault = rsrx_pkg::RSRX_LF_REMOTE;
      end
      // any other lane-3 value is reserved and ignored R21
    end
  endfunction : col_fault

  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic [7:0] rxc_s1_r, rxc_s2_r, rxc_s3_r;
  logic [63:0] rxd_s1_r, rxd_s2_r, rxd_s3_r;
  logic col_stb;

  // two-flop synchronisers, plus a third stage so data is the pre-edge value
  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      rxc_s1_r <= 8'h00;
      rxc_s2_r <= 8'h00;
      rxc_s3_r <= 8'h00;
      rxd_s1_r <= 64'h0;
      rxd_s2_r <= 64'h0;
      rxd_s3_r <= 64'h0;
    end else begin
      clk_s1_r <= rx_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      rxc_s1_r <= rxc;
      rxc_s2_r <= rxc_s1_r;
      rxc_s3_r <= rxc_s2_r;
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
      rxd_s3_r <= rxd_s2_r;
    end
  end

  // one column per rising receive clock edge R2 R15
  assign col_stb = clk_s2_r & ~clk_s3_r;

  rsrx_pkg::rsrx_frame_t frame_r, frame_nxt;
  logic [63:0] dat_nxt;
  logic [7:0] vld_nxt;
  logic err_nxt, end_nxt, dv_nxt;

  // column decode: start detection, data pass, error substitution
  always_comb begin
    logic ended;
    ended = 1'b0;
    frame_nxt = frame_r;
    dat_nxt = rxd_s3_r;
    vld_nxt = 8'h00;
    err_nxt = 1'b0;
    end_nxt = 1'b0;
    dv_nxt = 1'b0;
    if (frame_r == rsrx_pkg::RSRX_FR_IDLE) begin
      // only a lane-0 start with the delimiter in lane 7 opens a frame
      if (rxc_s3_r == 8'h01 && lane_byte(rxd_s3_r, 0) == rsrx_pkg::CODE_START && // R12
          lane_byte(rxd_s3_r, rsrx_pkg::SFD_LANE) == SFD_OCTET) begin // R13
        frame_nxt = rsrx_pkg::RSRX_FR_DATA;
        dat_nxt[7:0] = PRE_OCTET;
        vld_nxt = 8'hff;
        dv_nxt = 1'b1;
      end
    end else begin
      dv_nxt = 1'b1;
      for (int n = 0; n < rsrx_pkg::LANES; n++) begin
        if (!ended) begin
          if (!rxc_s3_r[n]) begin
            vld_nxt[n] = 1'b1; // R7
          end else if (lane_byte(rxd_s3_r, n) == rsrx_pkg::CODE_TERM) begin // R4
            ended = 1'b1; // R25
          end else begin
            // substituted octet plus error flag spoils the frame check R9
            dat_nxt[n*rsrx_pkg::LANE_W +: rsrx_pkg::LANE_W] = ERR_OCTET; // R10
            vld_nxt[n] = 1'b1;
            err_nxt = 1'b1;
            if (lane_byte(rxd_s3_r, n) != rsrx_pkg::CODE_ERR) begin
              ended = 1'b1; // R25
            end
          end
        end
      end
      if (ended) begin
        frame_nxt = rsrx_pkg::RSRX_FR_IDLE;
        end_nxt = 1'b1;
      end
    end
  end

  // frame state advances once per column
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_r <= rsrx_pkg::RSRX_FR_IDLE;
    end else if (col_stb) begin
      frame_r <= frame_nxt;
    end
  end

  // registered indications toward the mac
  always_ff @(posedge mclk) begin
    if (srst) begin
      mac_rxd <= 64'h0;
      mac_lane_vld <= 8'h00;
      mac_col_stb <= 1'b0;
      mac_dvalid <= 1'b0;
      mac_rx_err <= 1'b0;
      mac_frame_end <= 1'b0;
    end else begin
      mac_col_stb <= col_stb;
      mac_rx_err <= col_stb & err_nxt;
      mac_frame_end <= col_stb & end_nxt;
      if (col_stb) begin
        mac_rxd <= dat_nxt;
        mac_lane_vld <= vld_nxt;
        mac_dvalid <= dv_nxt;
      end
    end
  end

  rsrx_pkg::rsrx_fault_t lf_r, last_r, cur_fault;
  logic [rsrx_pkg::CNT_W-1:0] col_cnt_r;
  logic [rsrx_pkg::SEQ_W-1:0] seq_cnt_r;

  assign cur_fault = col_fault(rxc_s3_r, rxd_s3_r);

  // link fault monitor; counting is per column, not per mclk
  always_ff @(posedge mclk) begin
    if (srst) begin
      lf_r <= rsrx_pkg::RSRX_LF_OK; // R26
      last_r <= rsrx_pkg::RSRX_LF_OK;
      col_cnt_r <= '0;
      seq_cnt_r <= '0;
    end else if (col_stb) begin
      if (cur_fault != rsrx_pkg::RSRX_LF_OK) begin
        col_cnt_r <= '0;
        last_r <= cur_fault;
        if (cur_fault != last_r) begin
          // a different type restarts the run R23
          seq_cnt_r <= rsrx_pkg::SEQ_W'(1);
        end else if (seq_cnt_r < rsrx_pkg::SEQ_W'(rsrx_pkg::SEQ_SET)) begin
          seq_cnt_r <= seq_cnt_r + rsrx_pkg::SEQ_W'(1);
          if (seq_cnt_r == rsrx_pkg::SEQ_W'(rsrx_pkg::SEQ_SET - 1)) begin
            lf_r <= cur_fault; // R23
          end
        end
      end else if (col_cnt_r == rsrx_pkg::CNT_W'(rsrx_pkg::COL_LIMIT - 1)) begin
        // quiet span reached: back to ok R24
        lf_r <= rsrx_pkg::RSRX_LF_OK;
        last_r <= rsrx_pkg::RSRX_LF_OK;
        seq_cnt_r <= '0;
        col_cnt_r <= '0;
      end else begin
        col_cnt_r <= col_cnt_r + rsrx_pkg::CNT_W'(1);
      end
    end
  end

  assign link_fault = lf_r;

  // transmit steering from the held fault status
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_ovr_en <= 1'b0;
      tx_ovr_txd <= rsrx_pkg::IDLE_TXD;
      tx_ovr_txc <= rsrx_pkg::IDLE_TXC;
    end else begin
      case (lf_r)
        rsrx_pkg::RSRX_LF_LOCAL: begin
          tx_ovr_en <= 1'b1; // R16
          tx_ovr_txd <= rsrx_pkg::RF_TXD; // R20 R22
          tx_ovr_txc <= rsrx_pkg::RF_TXC;
        end
        rsrx_pkg::RSRX_LF_REMOTE: begin
          tx_ovr_en <= 1'b1; // R17
          tx_ovr_txd <= rsrx_pkg::IDLE_TXD;
          tx_ovr_txc <= rsrx_pkg::IDLE_TXC;
        end
        default: begin
          tx_ovr_en <= 1'b0; // R18
          tx_ovr_txd <= rsrx_pkg::IDLE_TXD;
          tx_ovr_txc <= rsrx_pkg::IDLE_TXC;
        end
      endcase
    end
  end

  // a frame cut short by a new fault gets an error character requested
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_force_err <= 1'b0;
    end else begin
      tx_force_err <= mac_tx_active & ~tx_ovr_en & (lf_r != rsrx_pkg::RSRX_LF_OK); // R11
    end
  end

  // checks on the decoder, the fault monitor and the transmit steering
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_idle_col;
    col_stb && frame_r == rsrx_pkg::RSRX_FR_IDLE;
  endsequence

  sequence s_data_col;
    col_stb && frame_r == rsrx_pkg::RSRX_FR_DATA;
  endsequence

  sequence s_local_held;
    lf_r == rsrx_pkg::RSRX_LF_LOCAL [*2];
  endsequence

  start_lane_zero_a: assert property ( // R12
    s_idle_col ##0 !(rxc_s3_r[0] && lane_byte(rxd_s3_r, 0) == rsrx_pkg::CODE_START) |=> !mac_dvalid)
    else $error("data valid raised without a lane 0 start");

  sfd_lane_seven_a: assert property ( // R13
    s_idle_col ##0 lane_byte(rxd_s3_r, rsrx_pkg::SFD_LANE) != SFD_OCTET |=> !mac_dvalid && !frame_r)
    else $error("frame opened with delimiter outside lane 7");

  data_lane_pass_a: assert property ( // R7
    s_data_col ##0 rxc_s3_r == 8'h00 |=> mac_lane_vld == 8'hff && mac_rxd == $past(rxd_s3_r))
    else $error("data column not passed to the mac");

  ctrl_err_flag_a: assert property ( // R9
    s_data_col ##0 rxc_s3_r[0] && lane_byte(rxd_s3_r, 0) != rsrx_pkg::CODE_TERM |=> mac_rx_err)
    else $error("control in frame did not flag an error");

  err_octet_sub_a: assert property ( // R10
    s_data_col ##0 rxc_s3_r == 8'h01 && lane_byte(rxd_s3_r, 0) == rsrx_pkg::CODE_ERR
      |=> mac_lane_vld[0] && mac_rxd[7:0] == ERR_OCTET && frame_r == rsrx_pkg::RSRX_FR_DATA)
    else $error("error character not substituted");

  term_ends_frame_a: assert property ( // R25
    s_data_col ##0 rxc_s3_r[0] && lane_byte(rxd_s3_r, 0) != rsrx_pkg::CODE_ERR
      |=> !frame_r && mac_frame_end ##1 !mac_frame_end)
    else $error("frame did not end on lane 0 control");

  fault_set_four_a: assert property ( // R23
    lf_r != $past(lf_r) && lf_r != rsrx_pkg::RSRX_LF_OK
      |-> $past(seq_cnt_r) == rsrx_pkg::SEQ_W'(rsrx_pkg::SEQ_SET - 1) && $past(col_stb))
    else $error("fault set without four matching sets");

  fault_clear_quiet_a: assert property ( // R24
    col_stb && cur_fault == rsrx_pkg::RSRX_LF_OK && col_cnt_r == rsrx_pkg::CNT_W'(rsrx_pkg::COL_LIMIT - 1)
      |=> lf_r == rsrx_pkg::RSRX_LF_OK && col_cnt_r == '0)
    else $error("fault not cleared after quiet span");

  reserved_seq_a: assert property ( // R21
    col_stb && cur_fault == rsrx_pkg::RSRX_LF_OK |=> seq_cnt_r == $past(seq_cnt_r) || seq_cnt_r == '0)
    else $error("reserved set counted as fault");

  remote_fault_tx_a: assert property ( // R16
    s_local_held |-> tx_ovr_en && tx_ovr_txd == rsrx_pkg::RF_TXD && tx_ovr_txc == rsrx_pkg::RF_TXC)
    else $error("local fault did not send remote fault");

  idle_on_remote_a: assert property ( // R17
    lf_r == rsrx_pkg::RSRX_LF_REMOTE |=> tx_ovr_en && tx_ovr_txc == rsrx_pkg::IDLE_TXC)
    else $error("remote fault did not force idle");

  resume_on_ok_a: assert property ( // R18
    lf_r == rsrx_pkg::RSRX_LF_OK |=> !tx_ovr_en)
    else $error("transmit still overridden while ok");

  reset_clears_a: assert property ( // R26
    @(posedge mclk) disable iff (1'b0) srst |=> lf_r == rsrx_pkg::RSRX_LF_OK && seq_cnt_r == '0 && col_cnt_r == '0)
    else $error("reset did not clear fault state");

endmodule : rsrx_top

// File: rsrx_phy_model.sv
// rsrx_phy_model: receive side of the phy, a free running link clock and
// one column of control and data launched per rising link edge.
// assumes the bench calls send_col once per column, in order; each call
// also launches one filler column after it.
`timescale 1ns/1ps

module rsrx_phy_model (
  output logic rx_clk,
  output logic [7:0] rxc,
  output logic [63:0] rxd
);
  // link clock runs free at eight mclk periods; the odd offset keeps its edges off the mclk edges
  initial begin
    rx_clk = 1'b0;
    rxc = 8'hff;
    rxd = 64'h0707_0707_0707_0707;
    #7.3;
    forever #80 rx_clk = ~rx_clk;
  end

  // control and data change only just after the rising link edge; a column
  // launched on one edge is taken on the next, so a filler follows it and
  // the bench can look at the answer before anything else is launched
  task automatic send_col(input logic [7:0] c, input logic [63:0] d, input logic open_f);
    @(posedge rx_clk);
    rxc <= c;
    rxd <= d;
    @(posedge rx_clk);
    // filler is plain data inside an open frame, idle outside it
    rxc <= open_f ? 8'h00 : 8'hff;
    rxd <= open_f ? 64'h0 : 64'h0707_0707_0707_0707;
  endtask : send_col
endmodule : rsrx_phy_model

// File: tb.sv
// tb: drives the receive decoder through the phy model and checks mac-side
// columns, fault status and transmit steering.
// assumes rsrx_pkg, rsrx_top and rsrx_phy_model are compiled first.
`timescale 1ns/1ps

module tb;
  logic mclk, srst, mac_tx_active, rx_clk;
  logic [7:0] rxc, mac_lane_vld, tx_ovr_txc, m;
  logic [63:0] rxd, mac_rxd, tx_ovr_txd, d;
  logic mac_col_stb, mac_dvalid, mac_rx_err, mac_frame_end, tx_ovr_en, tx_force_err;
  logic [1:0] link_fault;
  logic err_seen, end_seen, force_seen, fill_open;
  logic [7:0] stb_cnt;
  logic [7:0] codes [4] = '{rsrx_pkg::CODE_IDLE, rsrx_pkg::CODE_SEQ, rsrx_pkg::CODE_START, 8'h3c};
  int fail_count, samples_checked, seed, j;

  rsrx_phy_model phy_u (.rx_clk(rx_clk), .rxc(rxc), .rxd(rxd));
  rsrx_top dut_u (.mclk(mclk), .srst(srst), .rx_clk(rx_clk), .rxc(rxc), .rxd(rxd), .mac_tx_active(mac_tx_active),
    .mac_rxd(mac_rxd), .mac_lane_vld(mac_lane_vld), .mac_col_stb(mac_col_stb), .mac_dvalid(mac_dvalid),
    .mac_rx_err(mac_rx_err), .mac_frame_end(mac_frame_end), .link_fault(link_fault), .tx_ovr_en(tx_ovr_en),
    .tx_ovr_txd(tx_ovr_txd), .tx_ovr_txc(tx_ovr_txc), .tx_force_err(tx_force_err));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // widen a lane mask to a bit mask
  function automatic logic [63:0] lane_mask(input logic [7:0] v);
    logic [63:0] r;
    for (int n = 0; n < 8; n++) r[8*n +: 8] = {8{v[n]}};
    return r;
  endfunction : lane_mask

  // sequence column with the given type octet on lane 3
  function automatic logic [63:0] fault_col(input logic [7:0] kind);
    return {32'h0, kind, 16'h0, rsrx_pkg::CODE_SEQ};
  endfunction : fault_col

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // one column through the phy; it returns on the edge that takes the
  // column, then pulses are gathered over six mclk, which covers the 3-4
  // cycle answer and ends before the filler is taken
  task automatic col(input logic [7:0] c, input logic [63:0] v);
    phy_u.send_col(c, v, fill_open);
    err_seen = 1'b0;
    end_seen = 1'b0;
    force_seen = 1'b0;
    stb_cnt = 8'h00;
    repeat (6) begin
      @(posedge mclk);
      #1;
      err_seen |= mac_rx_err;
      end_seen |= mac_frame_end;
      force_seen |= tx_force_err;
      stb_cnt = stb_cnt + {7'h0, mac_col_stb};
    end
    chk("col_stb", 8'h01, stb_cnt);
  endtask : col

  task automatic start_frame;
    fill_open = 1'b1;
    col(8'h01, {8'hd5, {6{8'h55}}, rsrx_pkg::CODE_START});
    chk("start_dvalid", 1'b1, mac_dvalid);
    chk("start_data", {8'hd5, {7{8'h55}}}, mac_rxd);
  endtask : start_frame

  initial begin
    #200_000;
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    seed = 72255;
    fill_open = 1'b0;
    srst = 1'b1;
    mac_tx_active = 1'b0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("reset_fault", 2'b00, link_fault);
    // frames of random data, terminate on every lane in turn
    for (int k = 0; k < 8; k++) begin
      start_frame();
      repeat (2) begin
        d = {$random(seed), $random(seed)};
        col(8'h00, d);
        chk("data", d, mac_rxd);
        chk("data_lanes", 8'hff, mac_lane_vld);
      end
      d = {$random(seed), $random(seed)};
      for (int n = k; n < 8; n++) d[8*n +: 8] = (n == k) ? rsrx_pkg::CODE_TERM : rsrx_pkg::CODE_IDLE;
      m = ~(8'hff << k);
      fill_open = 1'b0;
      col(8'hff << k, d);
      chk("term_end", 1'b1, end_seen);
      chk("term_lanes", m, mac_lane_vld);
      chk("term_data", d & lane_mask(m), mac_rxd & lane_mask(m));
      col(8'hff, rsrx_pkg::IDLE_TXD);
      chk("after_dvalid", 1'b0, mac_dvalid);
    end
    $display("frame tests done");
    // error keeps the frame open; any other non-terminate control ends it with an error
    foreach (codes[i]) begin
      start_frame();
      // lane 0 is forced once for the error and once for the abort
      j = (i == 0) ? 0 : {$random(seed)} % 8;
      d = {$random(seed), $random(seed)};
      d[8*j +: 8] = rsrx_pkg::CODE_ERR;
      col(8'h01 << j, d);
      chk("err_flag", 1'b1, err_seen);
      chk("err_octet", 8'h00, mac_rxd[8*j +: 8]);
      chk("err_dvalid", 1'b1, mac_dvalid);
      j = (i == 1) ? 0 : {$random(seed)} % 8;
      d[8*j +: 8] = codes[i];
      fill_open = 1'b0;
      col(8'h01 << j, d);
      chk("abort_err", 1'b1, err_seen);
      chk("abort_end", 1'b1, end_seen);
      col(8'hff, rsrx_pkg::IDLE_TXD);
      chk("abort_dvalid", 1'b0, mac_dvalid);
    end
    $display("error tests done");
    // start off lane 0, or without the delimiter in lane 7, opens nothing
    for (int k = 1; k < 8; k++) begin
      d = {8'hd5, {7{8'h55}}};
      d[8*k +: 8] = rsrx_pkg::CODE_START;
      col(8'h01 << k, d);
      col(8'h00, d);
      chk("lane_start_dvalid", 1'b0, mac_dvalid);
    end
    col(8'h01, {8'hd4, {6{8'h55}}, rsrx_pkg::CODE_START});
    col(8'h00, d);
    chk("sfd_dvalid", 1'b0, mac_dvalid);
    $display("start tests done");
    // an intervening remote set restarts the local count
    repeat (3) col(8'h01, fault_col(rsrx_pkg::SEQ_LOCAL));
    col(8'h01, fault_col(rsrx_pkg::SEQ_REMOTE));
    repeat (3) col(8'h01, fault_col(rsrx_pkg::SEQ_LOCAL));
    chk("mixed_fault", 2'b00, link_fault);
    @(posedge mclk);
    mac_tx_active <= 1'b1;
    col(8'h01, fault_col(rsrx_pkg::SEQ_LOCAL));
    mac_tx_active <= 1'b0;
    chk("local_fault", 2'b01, link_fault);
    chk("local_force", 1'b1, force_seen);
    chk("local_ovr", 1'b1, tx_ovr_en);
    chk("local_txd", 64'h0000_0000_0200_009c, tx_ovr_txd);
    chk("local_txc", 8'h01, tx_ovr_txc);
    chk("fault_dvalid", 1'b0, mac_dvalid);
    // reset in mid-run drops the held fault
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("rst_fault", 2'b00, link_fault);
    chk("rst_ovr", 1'b0, tx_ovr_en);
    repeat (3) col(8'h01, fault_col(rsrx_pkg::SEQ_REMOTE));
    chk("remote_three", 2'b00, link_fault);
    col(8'h01, fault_col(rsrx_pkg::SEQ_REMOTE));
    chk("remote_fault", 2'b10, link_fault);
    chk("remote_ovr", 1'b1, tx_ovr_en);
    chk("remote_txd", 64'h0707_0707_0707_0707, tx_ovr_txd);
    chk("remote_txc", 8'hff, tx_ovr_txc);
    // reserved sets count as plain columns toward the 128 column span
    repeat (4) col(8'h01, fault_col(8'h03));
    chk("reserved_hold", 2'b10, link_fault);
    // each call takes a filler and its own column: 8 + 2 * 59 = 126 quiet
    repeat (59) col(8'hff, rsrx_pkg::IDLE_TXD);
    chk("span_126", 2'b10, link_fault);
    // the idle filler then stands for the 127th and the 128th column
    @(posedge rx_clk);
    repeat (6) @(posedge mclk);
    #1;
    chk("span_127", 2'b10, link_fault);
    @(posedge rx_clk);
    repeat (6) @(posedge mclk);
    #1;
    chk("span_128", 2'b00, link_fault);
    chk("resume_ovr", 1'b0, tx_ovr_en);
    $display("fault tests done");
    finish_test();
  end
endmodule : tb
